/* rtl/pkc_pkg.sv */
package pkc_pkg;

   // ----------------------------------------------------------------
   // Instruction word layout
   // ----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int SRC_SEL_W = 9;
   localparam int SRC0_SEL_LSB = 0;
   localparam int SRC1_SEL_LSB = 13;
   localparam int OPCODE_LSB = 7;
   localparam int OPCODE_W = 11;
   localparam int DST_GPR_LSB = 21;
   localparam int DST_GPR_W = 7;
   localparam int WRITE_MASK_BIT = 4;

   // ----------------------------------------------------------------
   // Opcodes in the two-source opcode field
   // ----------------------------------------------------------------
   localparam logic [10:0] OP_DISCARD_IF_EQUAL_FLOAT = 11'h02c;
   localparam logic [10:0] OP_DISCARD_IF_GT_FLOAT = 11'h02d;
   localparam logic [10:0] OP_DISCARD_IF_GE_FLOAT = 11'h02e;
   localparam logic [10:0] OP_DISCARD_IF_UNEQUAL_FLOAT = 11'h02f;
   localparam logic [10:0] OP_DISCARD_IF_GT_UNSIGNED = 11'h040;
   localparam logic [10:0] OP_DISCARD_IF_GE_UNSIGNED = 11'h041;
   localparam logic [10:0] OP_DISCARD_IF_EQUAL_SIGNED = 11'h046;
   localparam logic [10:0] OP_DISCARD_IF_GT_SIGNED = 11'h047;
   localparam logic [10:0] OP_DISCARD_IF_GE_SIGNED = 11'h048;

   // ----------------------------------------------------------------
   // Result constants and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] FLOAT_ONE = 32'h3f80_0000;
   localparam logic [31:0] FLOAT_ZERO = 32'h0000_0000;
   localparam logic DISCARD_RESET = 1'b0;

   typedef enum logic [2:0] {
      PKC_CMP_EQ = 3'h0,
      PKC_CMP_NE = 3'h1,
      PKC_CMP_GT = 3'h2,
      PKC_CMP_GE = 3'h3
   } pkc_cmp_e;

   typedef enum logic [2:0] {
      PKC_KIND_FLOAT = 3'h1,
      PKC_KIND_SIGNED = 3'h2,
      PKC_KIND_UNSIGNED = 3'h4
   } pkc_kind_e;

   // Issued instruction with its fetched operands
   typedef struct packed {
      logic [31:0] high_word;
      logic [31:0] low_word;
      logic [31:0] src0;
      logic [31:0] src1;
   } pkc_issue_s;

   // Destination write toward the register file
   typedef struct packed {
      logic [6:0] gpr;
      logic [31:0] data;
   } pkc_write_s;

endpackage

/* rtl/pkc_discard_unit.sv */
`timescale 1ns/1ps

module pkc_discard_unit
   import pkc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire pkc_issue_s issue,
   input wire logic pixel_program,
   input wire logic program_start,
   output logic write_valid,
   output pkc_write_s write,
   output logic discard_flag,
   output logic is_discard_op
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_sync1;
   logic rst_sync;

   // Asynchronous assert, two-stage synchronous release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1 <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_sync <= rst_sync1;
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [10:0] opcode;
   logic decoded;
   pkc_cmp_e cmp;
   pkc_kind_e kind;

   // Opcode sits in the high word, sources in the low word
   assign opcode = issue.high_word[OPCODE_LSB +: OPCODE_W];

   // Opcode map to comparison and operand kind
   always_comb begin
      decoded = 1'b1;
      cmp = PKC_CMP_EQ;
      kind = PKC_KIND_FLOAT;
      case (opcode)
         OP_DISCARD_IF_EQUAL_FLOAT: cmp = PKC_CMP_EQ;
         OP_DISCARD_IF_GT_FLOAT: cmp = PKC_CMP_GT;
         OP_DISCARD_IF_GE_FLOAT: cmp = PKC_CMP_GE;
         OP_DISCARD_IF_UNEQUAL_FLOAT: cmp = PKC_CMP_NE;
         OP_DISCARD_IF_GT_UNSIGNED: begin
            cmp = PKC_CMP_GT;
            kind = PKC_KIND_UNSIGNED;
         end
         OP_DISCARD_IF_GE_UNSIGNED: begin
            cmp = PKC_CMP_GE;
            kind = PKC_KIND_UNSIGNED;
         end
         OP_DISCARD_IF_EQUAL_SIGNED: begin
            cmp = PKC_CMP_EQ;
            kind = PKC_KIND_SIGNED;
         end
         OP_DISCARD_IF_GT_SIGNED: begin
            cmp = PKC_CMP_GT;
            kind = PKC_KIND_SIGNED;
         end
         OP_DISCARD_IF_GE_SIGNED: begin
            cmp = PKC_CMP_GE;
            kind = PKC_KIND_SIGNED;
         end
         default: decoded = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Compare
   // ----------------------------------------------------------------
   // Float order over raw bits: sign-magnitude to biased key.
   // Zeros of either sign map equal; NaN inputs fall into the
   // ordering of their bit pattern, a known limitation.
   function automatic logic [32:0] float_key(input logic [31:0] f);
      logic [32:0] key;
      key = '0;
      if (f[30:0] == 31'h0000_0000) begin
         key = {1'b1, 32'h0000_0000};
      end else if (f[31]) begin
         key = {1'b0, ~f};
      end else begin
         key = {1'b1, f};
      end
      return key;
   endfunction

   logic [32:0] key0;
   logic [32:0] key1;
   logic is_eq;
   logic is_gt;
   logic test_true;

   assign key0 = float_key(issue.src0);
   assign key1 = float_key(issue.src1);

   // Equality and greater-than per operand kind
   always_comb begin
      unique case (kind)
         PKC_KIND_SIGNED: begin
            is_eq = (issue.src0 == issue.src1);
            is_gt = ($signed(issue.src0) > $signed(issue.src1));
         end
         PKC_KIND_UNSIGNED: begin
            is_eq = (issue.src0 == issue.src1);
            is_gt = (issue.src0 > issue.src1);
         end
         default: begin
            is_eq = (key0 == key1);
            is_gt = (key0 > key1);
         end
      endcase
   end

   // Test selection
   always_comb begin
      unique case (cmp)
         PKC_CMP_EQ: test_true = is_eq;
         PKC_CMP_NE: test_true = !is_eq;
         PKC_CMP_GT: test_true = is_gt;
         PKC_CMP_GE: test_true = is_gt || is_eq;
         default: test_true = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Execute
   // ----------------------------------------------------------------
   logic execute;

   // Outside a pixel program the instruction writes nothing and sets no flag; is_discard_op still rises
   assign execute = issue_valid && decoded && pixel_program;
   assign is_discard_op = issue_valid && decoded;

   // Destination write, one cycle after issue
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         write_valid <= 1'b0;
         write <= '0;
      end else begin
         write_valid <= execute;
         if (execute) begin
            write.gpr <= issue.high_word[DST_GPR_LSB +: DST_GPR_W];
            write.data <= test_true ? FLOAT_ONE : FLOAT_ZERO;
         end
      end
   end

   // Sticky discard flag; a new program clears it, but a hit in the
   // same cycle wins so no discard is lost. Later ops in the clause
   // see the flag one cycle late, hence issue order matters.
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         discard_flag <= DISCARD_RESET;
      end else if (execute && test_true) begin
         discard_flag <= 1'b1;
      end else if (program_start) begin
         discard_flag <= DISCARD_RESET;
      end
   end

endmodule

/* tb/pkc_discard_unit_monitor.sv */
`timescale 1ns/1ps
module pkc_discard_unit_monitor
   import pkc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire pkc_issue_s issue,
   input wire logic pixel_program,
   input wire logic program_start,
   input wire logic write_valid,
   input wire pkc_write_s write,
   input wire logic discard_flag,
   input wire logic is_discard_op
);
   // ---------------------------------------------
   // Reference compare
   // ---------------------------------------------
   logic [31:0] a;
   logic [31:0] b;
   logic disc;
   logic hit;
   logic feq;
   logic fgt;
   // Bit keys order floats; both zero signs still match
   function automatic logic [31:0] key(input logic [31:0] x);
      return x[31] ? ~x : {1'b1, x[30:0]};
   endfunction
   always_comb begin
      a = issue.src0;
      b = issue.src1;
      feq = (a == b) || ((a[30:0] | b[30:0]) == 31'h0);
      fgt = !feq && (key(a) > key(b));
      disc = 1'b1;
      hit = 1'b0;
      case (issue.high_word[17:7])
         OP_DISCARD_IF_EQUAL_FLOAT: hit = feq;
         OP_DISCARD_IF_GT_FLOAT: hit = fgt;
         OP_DISCARD_IF_GE_FLOAT: hit = fgt || feq;
         OP_DISCARD_IF_UNEQUAL_FLOAT: hit = !feq;
         OP_DISCARD_IF_GT_UNSIGNED: hit = a > b;
         OP_DISCARD_IF_GE_UNSIGNED: hit = a >= b;
         OP_DISCARD_IF_EQUAL_SIGNED: hit = a == b;
         OP_DISCARD_IF_GT_SIGNED: hit = $signed(a) > $signed(b);
         OP_DISCARD_IF_GE_SIGNED: hit = $signed(a) >= $signed(b);
         default: disc = 1'b0;
      endcase
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      issue_valid && disc && pixel_program;
   endsequence
   chk_take_write: assert property (s_take |=> write_valid)
      else $error("no write after discard");
   chk_refuse_plain: assert property (!(issue_valid && disc && pixel_program) |=> !write_valid)
      else $error("write without discard");
   chk_result_value: assert property (s_take |=> write.data == ($past(hit) ? FLOAT_ONE : FLOAT_ZERO))
      else $error("wrong result value");
   chk_flag_set: assert property (s_take ##0 hit |=> discard_flag)
      else $error("flag not set");
   chk_flag_sticky: assert property (discard_flag && !program_start |=> discard_flag)
      else $error("flag dropped");
   chk_flag_quiet: assert property (!discard_flag && !(issue_valid && disc && pixel_program && hit) |=> !discard_flag)
      else $error("flag rose alone");
   chk_decode_flag: assert property (is_discard_op == (issue_valid && disc))
      else $error("decode flag wrong");
   chk_dest_gpr: assert property (s_take |=> write.gpr == $past(issue.high_word[27:21]))
      else $error("wrong destination");
endmodule
bind pkc_discard_unit pkc_discard_unit_monitor i_mon (.clock(clock), .rst_n(rst_n),
   .issue_valid(issue_valid), .issue(issue), .pixel_program(pixel_program),
   .program_start(program_start), .write_valid(write_valid), .write(write),
   .discard_flag(discard_flag), .is_discard_op(is_discard_op));

/* tb/pkc_sequencer_model.sv */
`timescale 1ns/1ps
module pkc_sequencer_model
   import pkc_pkg::*;
(
   input wire logic clock,
   output logic issue_valid,
   output pkc_issue_s issue
);
   // ---------------------------------------------
   // Issue one discard, called at a falling edge
   // ---------------------------------------------
   initial begin
      issue_valid = 1'b0;
      issue = '0;
   end
   // Sent back to back: the next send drives at the falling edge that ends this one
   task automatic send(input logic [10:0] op, input logic [31:0] a, input logic [31:0] b);
      issue_valid = 1'b1;
      issue = {4'h0, 7'h15, 3'h0, op, 7'h00, 32'h0000_2001, a, b};
      @(negedge clock);
      issue_valid = 1'b0;
      issue = ~issue; // Released bus shows garbage
   endtask
endmodule

/* tb/pkc_discard_unit_test.sv */
`timescale 1ns/1ps
module pkc_discard_unit_test
   import pkc_pkg::*;
;
   logic clock;
   logic rst_n;
   logic pixel_program;
   logic program_start;
   logic issue_valid;
   logic write_valid;
   logic discard_flag;
   pkc_issue_s issue;
   pkc_write_s write;
   int fail_count;
   int comparisons;
   localparam logic [10:0] OPS [9] = '{11'h02c, 11'h02d, 11'h02e, 11'h02f, 11'h040,
      11'h041, 11'h046, 11'h047, 11'h048};
   localparam logic [31:0] PA [3] = '{32'hbf80_0000, 32'h4000_0000, 32'h3f80_0000};
   localparam logic [31:0] PB [3] = '{32'h3f80_0000, 32'h4000_0000, 32'hbf80_0000};
   localparam logic [8:0] EXP [3] = '{9'h038, 9'h165, 9'h18e};
   // ---------------------------------------------
   // Clock, parts and checks
   // ---------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   pkc_sequencer_model i_seq (.clock(clock), .issue_valid(issue_valid), .issue(issue));
   pkc_discard_unit i_dut (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
      .issue(issue), .pixel_program(pixel_program), .program_start(program_start),
      .write_valid(write_valid), .write(write), .discard_flag(discard_flag),
      .is_discard_op());
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [10:0] op, input logic [31:0] a, input logic [31:0] b,
         input logic pp, input logic st, input logic wv, input logic hit, input logic fl);
      pixel_program = pp;
      program_start = st;
      i_seq.send(op, a, b);
      program_start = 1'b0;
      chk({31'h0, write_valid}, {31'h0, wv});
      if (wv) chk(write.data, hit ? FLOAT_ONE : FLOAT_ZERO);
      if (wv) chk({25'h0, write.gpr}, {25'h0, 7'h15});
      chk({31'h0, discard_flag}, {31'h0, fl});
   endtask
   task automatic t_all_ops;
      for (int i = 0; i < 9; i++) begin
         for (int p = 0; p < 3; p++) begin
            run(OPS[i], PA[p], PB[p], 1, 1, 1, EXP[p][i], EXP[p][i]);
         end
      end
   endtask
   task automatic t_sticky;
      run(OPS[0], PA[1], PB[1], 1, 1, 1, 1, 1);
      run(OPS[0], PA[0], PB[0], 1, 0, 1, 0, 1);
   endtask
   // Flag holds through an ignored op, a program start clears it, and an unknown op leaves it clear
   task automatic t_refuse;
      run(OPS[0], PA[1], PB[1], 0, 0, 0, 0, 1);
      run(OPS[3], PA[0], PB[0], 0, 1, 0, 0, 0);
      run(11'h049, PA[0], PB[0], 1, 0, 0, 0, 0);
   endtask
   task automatic stop_test;
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      fail_count = 0;
      comparisons = 0;
      rst_n = 1'b0;
      pixel_program = 1'b0;
      program_start = 1'b0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      t_all_ops();
      t_sticky();
      t_refuse();
      stop_test();
   end
   initial begin
      #4000;
      fail_count++;
      stop_test();
   end
endmodule
